// ---- logic/fci_defines.vh ----
// constants for the flash command controller: register map, fields,
// operation codes, unlock addresses and strobe timing.
// assumes a 125 MHz ref_clk; included by its bare name.
`ifndef FCI_DEFINES_VH
`define FCI_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte offsets on the apb)
// ----------------------------------------------------------------
`define FCI_REG_CTRL     8'h00
`define FCI_REG_CFG      8'h04
`define FCI_REG_ADDR     8'h08
`define FCI_REG_WDATA    8'h0C
`define FCI_REG_STATUS   8'h10
`define FCI_REG_RDATA    8'h14

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define FCI_ST_BUSY      0
`define FCI_ST_BYPASS    1
`define FCI_ST_IDMODE    2
`define FCI_ST_SUSPEND   3
`define FCI_ST_REFUSED   4
`define FCI_ST_DONE      5

// ----------------------------------------------------------------
// operation codes written to ctrl[3:0]
// ----------------------------------------------------------------
`define FCI_OP_READ      4'h0
`define FCI_OP_RESET     4'h1
`define FCI_OP_IDENTER   4'h2
`define FCI_OP_IDREAD    4'h3
`define FCI_OP_PROTVFY   4'h4
`define FCI_OP_PROGRAM   4'h5
`define FCI_OP_BYPENTER  4'h6
`define FCI_OP_BYPPROG   4'h7
`define FCI_OP_BYPEXIT   4'h8
`define FCI_OP_CHIPERASE 4'h9
`define FCI_OP_SUSPEND   4'hA
`define FCI_OP_RESUME    4'hB
`define FCI_OP_CODE5     4'hC

// ----------------------------------------------------------------
// address selectors held in the sequence table
// ----------------------------------------------------------------
`define FCI_SEL_UNLOCK1  3'h0
`define FCI_SEL_UNLOCK2  3'h1
`define FCI_SEL_TARGET   3'h2
`define FCI_SEL_PAGE     3'h3
`define FCI_SEL_SECTOR   3'h4
`define FCI_SEL_CODE     3'h5

// ----------------------------------------------------------------
// command bytes and unlock addresses
// ----------------------------------------------------------------
`define FCI_CMD_UNLOCKA  8'hAA
`define FCI_CMD_UNLOCKB  8'h55
`define FCI_CMD_RESET    8'hF0
`define FCI_CMD_IDENTER  8'h90
`define FCI_CMD_PROGRAM  8'hA0
`define FCI_CMD_BYPASS   8'h20
`define FCI_CMD_BYPEXIT2 8'h00
`define FCI_CMD_ERASESU  8'h80
`define FCI_CMD_CHIPERS  8'h10
`define FCI_CMD_SUSPEND  8'hB0
`define FCI_CMD_RESUME   8'h30
`define FCI_UNL1_WORD    19'h00555
`define FCI_UNL2_WORD    19'h002AA
`define FCI_UNL1_BYTE    19'h00AAA
`define FCI_UNL2_BYTE    19'h00555
`define FCI_PROT_WORD    19'h00002
`define FCI_PROT_BYTE    19'h00004
`define FCI_PAGE_BIT     19'h00040
`define FCI_CODE_MASK    19'h00043

// ----------------------------------------------------------------
// strobe timing: ns figures and derived 8 ns clock counts (round up)
// ----------------------------------------------------------------
`define FCI_CLK_NS       8
`define FCI_T_WP_NS      40
`define FCI_T_WPH_NS     30
`define FCI_T_ACC_NS     80
`define FCI_WP_CYC       ((`FCI_T_WP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WPH_CYC      ((`FCI_T_WPH_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_ACC_CYC      ((`FCI_T_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)

`endif

// ---- logic/fci_seq_rom.v ----
// sequence table: one entry per bus cycle of each operation.
// assumes the caller presents {op, step} and waits one clock for data.
`timescale 1ns/100ps
`default_nettype none
`include "fci_defines.vh"

module fci_seq_rom (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire [6:0]  rdAddr,
	output reg  [12:0] rdData
);

	// entry layout: {last, isRead, sel[2:0], cmd[7:0]}
	function [12:0] ent;
		input       last;
		input       isRd;
		input [2:0] sel;
		input [7:0] cmd;
		begin
			ent = {last, isRd, sel, cmd};
		end
	endfunction

	// ----------------------------------------------------------------
	// registered lookup
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 13'h0000;
		end else begin
			case (rdAddr)
				{`FCI_OP_READ, 3'd0}:      rdData <= ent(1'b1, 1'b1, `FCI_SEL_TARGET, 8'h00);
				{`FCI_OP_RESET, 3'd0}:     rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_RESET);
				{`FCI_OP_IDENTER, 3'd0},
				{`FCI_OP_PROGRAM, 3'd0},
				{`FCI_OP_BYPENTER, 3'd0},
				{`FCI_OP_CHIPERASE, 3'd0},
				{`FCI_OP_CHIPERASE, 3'd3}: rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_UNLOCKA);
				{`FCI_OP_IDENTER, 3'd1},
				{`FCI_OP_PROGRAM, 3'd1},
				{`FCI_OP_BYPENTER, 3'd1},
				{`FCI_OP_CHIPERASE, 3'd1},
				{`FCI_OP_CHIPERASE, 3'd4}: rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK2, `FCI_CMD_UNLOCKB);
				{`FCI_OP_IDENTER, 3'd2}:   rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_IDENTER);
				{`FCI_OP_IDREAD, 3'd0}:    rdData <= ent(1'b1, 1'b1, `FCI_SEL_TARGET, 8'h00);
				{`FCI_OP_PROTVFY, 3'd0}:   rdData <= ent(1'b1, 1'b1, `FCI_SEL_SECTOR, 8'h00);
				{`FCI_OP_PROGRAM, 3'd2}:   rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_PROGRAM);
				{`FCI_OP_PROGRAM, 3'd3},
				{`FCI_OP_BYPPROG, 3'd1}:   rdData <= ent(1'b1, 1'b0, `FCI_SEL_TARGET, 8'h00);
				{`FCI_OP_BYPENTER, 3'd2}:  rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_BYPASS);
				{`FCI_OP_BYPPROG, 3'd0}:   rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_PROGRAM);
				{`FCI_OP_BYPEXIT, 3'd0}:   rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_IDENTER);
				{`FCI_OP_BYPEXIT, 3'd1}:   rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_BYPEXIT2);
				{`FCI_OP_CHIPERASE, 3'd2}: rdData <= ent(1'b0, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_ERASESU);
				{`FCI_OP_CHIPERASE, 3'd5}: rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_CHIPERS);
				{`FCI_OP_SUSPEND, 3'd0}:   rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_SUSPEND);
				{`FCI_OP_RESUME, 3'd0}:    rdData <= ent(1'b1, 1'b0, `FCI_SEL_UNLOCK1, `FCI_CMD_RESUME);
				{`FCI_OP_CODE5, 3'd0},
				{`FCI_OP_CODE5, 3'd1},
				{`FCI_OP_CODE5, 3'd2},
				{`FCI_OP_CODE5, 3'd3}:     rdData <= ent(1'b0, 1'b1, `FCI_SEL_PAGE, 8'h00);
				{`FCI_OP_CODE5, 3'd4}:     rdData <= ent(1'b1, 1'b1, `FCI_SEL_CODE, 8'h00);
				// unknown entries end at once as a harmless read
				default:                   rdData <= ent(1'b1, 1'b1, `FCI_SEL_TARGET, 8'h00);
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- logic/fci_host_ctrl.v ----
// host-side controller for an asynchronous parallel nor flash: takes
// orders over apb and plays the command sequences on the flash pins.
// assumes flash pins are timed from ref_clk and dq input is synchronous.
//
// How it works
// - all sequence cycles write except reads
// - reset command leaves identification mode
// - id entry: two unlocks then command
// - program: unlocks, setup, address and data
// - commands ignored while programming runs
// - bypass entry 20h, then A0h plus data
// - bypass exit writes 90h then 00h
// - chip erase takes six writes
`timescale 1ns/100ps
`default_nettype none
`include "fci_defines.vh"

module fci_host_ctrl #(
	parameter ADDR_W  = 19,
	parameter WP_CYC  = `FCI_WP_CYC,
	parameter WPH_CYC = `FCI_WPH_CYC,
	parameter ACC_CYC = `FCI_ACC_CYC
) (
	input  wire              ref_clk,
	input  wire              nrst,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output reg               pready,
	output reg  [31:0]       prdata,
	output reg               pslverr,
	output reg  [ADDR_W-1:0] flashAddr,
	output reg  [15:0]       dqOut,
	output reg               dqOe,
	input  wire [15:0]       dqIn,
	output reg               ceN,
	output reg               weN,
	output reg               oeN,
	output reg               byteN
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam S_IDLE   = 6'b000001;
	localparam S_FETCH  = 6'b000010;
	localparam S_SETUP  = 6'b000100;
	localparam S_STROBE = 6'b001000;
	localparam S_HOLD   = 6'b010000;
	localparam S_READ   = 6'b100000;

	reg [5:0]        state_q;
	reg [7:0]        cnt_q;
	reg [3:0]        op_q;
	reg [2:0]        step_q;
	reg              byteMode_q;
	reg [ADDR_W-1:0] target_q;
	reg [15:0]       wdata_q;
	reg [15:0]       rdata_q;
	reg              bypass_q;
	reg              idMode_q;
	reg              suspend_q;
	reg              refused_q;
	reg              done_q;
	reg              last_q;
	wire [12:0]      romData;
	wire             romLast  = romData[12];
	wire             romRead  = romData[11];
	wire [2:0]       romSel   = romData[10:8];
	wire [7:0]       romCmd   = romData[7:0];

	// ----------------------------------------------------------------
	// address forming
	// ----------------------------------------------------------------
	function [ADDR_W-1:0] addrFor;
		input [2:0]        sel;
		input              bm;
		input [ADDR_W-1:0] tgt;
		reg   [ADDR_W-1:0] secMask;
		begin
			// sector bits are the top six of either address form
			secMask = {6'h3F, {(ADDR_W-6){1'b0}}} >> (bm ? 0 : 1);
			case (sel)
				`FCI_SEL_UNLOCK1: addrFor = bm ? `FCI_UNL1_BYTE : `FCI_UNL1_WORD;
				`FCI_SEL_UNLOCK2: addrFor = bm ? `FCI_UNL2_BYTE : `FCI_UNL2_WORD;
				`FCI_SEL_SECTOR:  addrFor = (tgt & secMask)
					| (bm ? `FCI_PROT_BYTE : `FCI_PROT_WORD);
				// byte mode carries the extra low bit, so code bits sit one up
				`FCI_SEL_PAGE:    addrFor = (tgt & ~(`FCI_CODE_MASK << bm))
					| (`FCI_PAGE_BIT << bm);
				`FCI_SEL_CODE:    addrFor = tgt & ~(`FCI_CODE_MASK << bm);
				default:          addrFor = tgt;
			endcase
		end
	endfunction

	// refusal check against the tracked device mode
	function refuse;
		input [3:0] op;
		input       byp;
		input       idm;
		input       sus;
		begin
			if (byp) begin
				refuse = !(op == `FCI_OP_PROGRAM || op == `FCI_OP_BYPPROG
					|| op == `FCI_OP_BYPEXIT || op == `FCI_OP_READ);
			end else begin
				case (op)
					`FCI_OP_BYPPROG, `FCI_OP_BYPEXIT: refuse = 1'b1;
					`FCI_OP_IDREAD, `FCI_OP_PROTVFY,
					`FCI_OP_CODE5:    refuse = !idm;
					`FCI_OP_IDENTER:  refuse = idm;
					`FCI_OP_SUSPEND:  refuse = sus;
					`FCI_OP_RESUME:   refuse = !sus;
					default:          refuse = 1'b0;
				endcase
			end
		end
	endfunction

	fci_seq_rom u_rom (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.rdAddr  ({op_q, step_q}),
		.rdData  (romData)
	);

	// ----------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ----------------------------------------------------------------
	wire       acc     = psel && penable && !pready;
	wire       commit  = psel && penable && pready;
	wire       wrCommit = commit && pwrite;
	wire       mapped  = (paddr <= `FCI_REG_RDATA) && (paddr[1:0] == 2'b00);
	wire [3:0] newOp   = pwdata[3:0];
	wire       start   = wrCommit && paddr == `FCI_REG_CTRL && state_q == S_IDLE;
	wire       startOk = start && !refuse(newOp, bypass_q, idMode_q, suspend_q);
	wire       seqEnd  = state_q == S_HOLD && cnt_q == 8'h00 && last_q;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= acc;
			pslverr <= acc && !mapped;
			case (paddr)
				`FCI_REG_CTRL:   prdata <= {28'h0000000, op_q};
				`FCI_REG_CFG:    prdata <= {31'h00000000, byteMode_q};
				`FCI_REG_ADDR:   prdata <= {{(32-ADDR_W){1'b0}}, target_q};
				`FCI_REG_WDATA:  prdata <= {16'h0000, wdata_q};
				`FCI_REG_STATUS: prdata <= {26'h0000000, done_q, refused_q, suspend_q,
					idMode_q, bypass_q, state_q != S_IDLE};
				`FCI_REG_RDATA:  prdata <= {16'h0000, rdata_q};
				default:         prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// software registers; hardware set wins over write-one clear
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			byteMode_q <= 1'b0;
			target_q   <= {ADDR_W{1'b0}};
			wdata_q    <= 16'h0000;
			refused_q  <= 1'b0;
			done_q     <= 1'b0;
		end else begin
			if (wrCommit && paddr == `FCI_REG_CFG && state_q == S_IDLE)
				byteMode_q <= pwdata[0];
			if (wrCommit && paddr == `FCI_REG_ADDR)
				target_q <= pwdata[ADDR_W-1:0];
			if (wrCommit && paddr == `FCI_REG_WDATA)
				wdata_q <= pwdata[15:0];
			if (wrCommit && paddr == `FCI_REG_STATUS && pwdata[`FCI_ST_REFUSED])
				refused_q <= 1'b0;
			if (start && !startOk)
				refused_q <= 1'b1;
			if (wrCommit && paddr == `FCI_REG_STATUS && pwdata[`FCI_ST_DONE])
				done_q <= 1'b0;
			if (seqEnd)
				done_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// tracked device mode, updated when a sequence completes
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bypass_q  <= 1'b0;
			idMode_q  <= 1'b0;
			suspend_q <= 1'b0;
		end else if (seqEnd) begin
			case (op_q)
				`FCI_OP_BYPENTER: bypass_q  <= 1'b1;
				`FCI_OP_BYPEXIT:  bypass_q  <= 1'b0;
				`FCI_OP_IDENTER:  idMode_q  <= 1'b1;
				`FCI_OP_RESET:    idMode_q  <= 1'b0;
				`FCI_OP_SUSPEND:  suspend_q <= 1'b1;
				`FCI_OP_RESUME:   suspend_q <= 1'b0;
				default:          idMode_q  <= idMode_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus cycle engine
	// ----------------------------------------------------------------
	// address is set a cycle before ce/we fall and kept through hold,
	// so either falling edge sees it; data stays until hold ends, after ce rises.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= S_IDLE;
			cnt_q     <= 8'h00;
			op_q      <= `FCI_OP_READ;
			step_q    <= 3'd0;
			last_q    <= 1'b0;
			rdata_q   <= 16'h0000;
			flashAddr <= {ADDR_W{1'b0}};
			dqOut     <= 16'h0000;
			dqOe      <= 1'b0;
			ceN       <= 1'b1;
			weN       <= 1'b1;
			oeN       <= 1'b1;
			byteN     <= 1'b1;
		end else begin
			byteN <= !byteMode_q;
			case (state_q)
				S_IDLE: begin
					if (startOk) begin
						// bypass mode shortens program to two writes
						op_q   <= (bypass_q && newOp == `FCI_OP_PROGRAM)
							? `FCI_OP_BYPPROG : newOp;
						step_q <= 3'd0;
						state_q <= S_FETCH;
					end
				end
				S_FETCH: begin
					state_q   <= S_SETUP;
				end
				S_SETUP: begin
					last_q    <= romLast;
					flashAddr <= addrFor(romSel, byteMode_q, target_q);
					dqOe      <= !romRead;
					if (romSel == `FCI_SEL_TARGET && !romRead)
						dqOut <= byteMode_q ? {8'h00, wdata_q[7:0]} : wdata_q;
					else
						dqOut <= {8'h00, romCmd};
					state_q   <= romRead ? S_READ : S_STROBE;
					cnt_q     <= romRead ? ACC_CYC[7:0] : WP_CYC[7:0];
				end
				S_STROBE: begin
					ceN <= 1'b0;
					weN <= 1'b0;
					if (cnt_q == 8'h00) begin
						// we rises first; ce follows so data meets first rise
						weN     <= 1'b1;
						state_q <= S_HOLD;
						cnt_q   <= WPH_CYC[7:0];
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				S_READ: begin
					ceN <= 1'b0;
					oeN <= 1'b0;
					if (cnt_q == 8'h00) begin
						rdata_q <= byteMode_q ? {8'h00, dqIn[7:0]} : dqIn;
						oeN     <= 1'b1;
						state_q <= S_HOLD;
						cnt_q   <= WPH_CYC[7:0];
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				S_HOLD: begin
					ceN <= 1'b1;
					if (cnt_q == 8'h00) begin
						dqOe   <= 1'b0;
						step_q <= step_q + 3'd1;
						// each write of the table goes out in order
						state_q <= last_q ? S_IDLE : S_FETCH;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- logic/fci_dummy_unused.v ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- tb/fci_flash_model.sv ----
// flash device model: decodes command cycles and answers reads on dq.
// assumes the bench resolves dq from dqOe and clears evLog after reset.
`timescale 1ns/100ps
`default_nettype none

module fci_flash_model #(
	parameter [7:0] MAKER = 8'h3C, // arbitrary value
	parameter [7:0] CONT  = 8'h5A, // arbitrary value
	parameter [7:0] DEVID = 8'h66, // arbitrary value
	parameter [5:0] PSEC  = 6'h05
) (
	input  wire logic        ceN,
	input  wire logic        weN,
	input  wire logic        oeN,
	input  wire logic        byteN,
	input  wire logic [18:0] flashAddr,
	input  wire logic [15:0] dq,
	output var  logic [15:0] dqDrv
);
	logic [35:0] evLog[$];
	logic [15:0] mem[int];
	logic [15:0] rdVal = 16'h0000;
	logic [15:0] lastD = 16'h0000;
	logic [18:0] latA  = 19'h00000;
	logic [7:0]  d;
	int          step  = 0;
	logic        idm   = 0;
	logic        byp   = 0;
	logic        pend  = 0;
	wire         wStb  = ceN | weN;
	wire  [18:0] wa    = byteN ? flashAddr : flashAddr >> 1;
	wire  [10:0] la    = byteN ? latA[10:0] : latA[11:1];

	// ----------------------------------------------------------------
	// command decoder
	// ----------------------------------------------------------------
	// address at the later falling strobe
	always @(negedge wStb) latA = flashAddr;
	// data at the earlier rising strobe; upper lanes and bits ignored except for word-mode program data
	always @(posedge wStb) begin
		d = dq[7:0];
		evLog.push_back({1'b0, latA, dq});
		if (pend) begin
			mem[latA] = (mem.exists(latA) ? mem[latA] : 16'hFFFF) & (byteN ? dq : {8'hFF, d});
			pend = 0;
		end else if (byp) begin
			pend = step == 0 && d == 8'hA0;
			byp = !(step == 1 && d == 8'h00);
			step = (step == 0 && d == 8'h90) ? 1 : 0;
		end else if (d == 8'hF0) begin
			idm = 0;
			step = 0;
		end else if (step == 0 || step == 3)
			step = (d == 8'hAA && la == 11'h555) ? step + 1 : 0;
		else if (step == 1 || step == 4)
			step = (d == 8'h55 && la == 11'h2AA) ? step + 1 : 0;
		else begin
			if (la == 11'h555 && step == 5 && d == 8'h10)
				mem.delete();
			if (la == 11'h555 && step == 2) begin
				idm = idm | (d == 8'h90);
				pend = d == 8'hA0;
				byp = d == 8'h20;
			end
			step = (la == 11'h555 && step == 2 && d == 8'h80) ? 3 : 0;
		end
		// no sector erase ever runs, so suspend and resume fall through
	end
	// identification answers chosen by the low word-address bits
	always @(negedge oeN) begin
		if (!idm)
			rdVal = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
		else if (wa[1:0] == 2'h2)
			rdVal = {15'h0000, wa[17:12] == PSEC};
		else if (wa[1:0] == 2'h1)
			rdVal = {8'h00, DEVID};
		else
			rdVal = {8'h00, wa[6] ? CONT : MAKER};
	end
	// released lines show the inverse, so a stale value never matches
	always @* dqDrv = (ceN || oeN) ? ~lastD : rdVal;
	always @(posedge oeN) if (!ceN) begin
		lastD = rdVal;
		evLog.push_back({1'b1, flashAddr, rdVal});
	end
endmodule
`default_nettype wire

// ---- tb/fci_host_ctrl_properties.sv ----
// pin and apb timing checks on the controller ports.
// assumes default strobe counts; bound to every controller instance.
`timescale 1ns/100ps
`default_nettype none

module fci_host_ctrl_properties #(
	parameter ADDR_W  = 19,
	parameter WP_CYC  = 5,
	parameter WPH_CYC = 4,
	parameter ACC_CYC = 10
) (
	input wire logic              ref_clk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic [15:0]       dqOut,
	input wire logic              dqOe,
	input wire logic              ceN,
	input wire logic              weN,
	input wire logic              oeN
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// strobe held low for its whole width
	sequence s_strobe_low;
		!weN [*5];
	endsequence
	// data kept on the lines past the rising strobe
	sequence s_data_held;
		dqOe && $stable(dqOut) ##1 dqOe && $stable(dqOut);
	endsequence
	a_addr_steady: assert property (!ceN && !weN && $past(!ceN && !weN) |-> $stable(flashAddr))
		else $error("address moved under write strobe");
	a_strobe_ce: assert property (!weN || !oeN |-> !ceN)
		else $error("strobe without chip select");
	a_data_hold: assert property ($rose(weN) |-> s_data_held)
		else $error("write data not held past strobe");
	a_strobe_width: assert property ($fell(weN) |-> s_strobe_low)
		else $error("write strobe too short");
	a_write_only: assert property (!weN |-> oeN && dqOe)
		else $error("write cycle not driving");
	a_read_released: assert property (!oeN |-> weN && !dqOe)
		else $error("read cycle while driving");
	a_cycle_gap: assert property ($rose(ceN) |-> ceN [*5])
		else $error("chip select gap too short");
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule

bind fci_host_ctrl fci_host_ctrl_properties #(
	.ADDR_W(ADDR_W), .WP_CYC(WP_CYC), .WPH_CYC(WPH_CYC), .ACC_CYC(ACC_CYC)
) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe),
	.ceN(ceN), .weN(weN), .oeN(oeN)
);
`default_nettype wire

// ---- tb/testbench.sv ----
// bench top: apb master, op scenarios and a shadow model of the flash.
// assumes controller default timing and the flash model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "fci_defines.vh"

module testbench;
	localparam [7:0]  MAKER = 8'h3C; // arbitrary value
	localparam [7:0]  DEVID = 8'h66; // arbitrary value
	localparam [7:0]  CONT  = 8'h5A; // arbitrary value
	localparam [35:0] FULL  = 36'hFFFFFFFFF;
	localparam [35:0] NOADR = 36'h80000FFFF;
	logic        ref_clk = 0;
	logic        nrst    = 0;
	logic        psel    = 0;
	logic        penable = 0;
	logic        pwrite  = 0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] rd;
	logic [31:0] rnd     = 32'hE837;
	logic        err;
	logic        bm = 0, idm = 0, byp = 0, sus = 0;
	logic [35:0] expQ[$];
	logic [35:0] mskQ[$];
	logic [15:0] bmem[int];
	int          n_fail = 0, check_count = 0, cyc = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, dqOe, ceN, weN, oeN, byteN;
	wire  [18:0] flashAddr;
	wire  [15:0] dqOut, dqDrv;
	wire  [15:0] dqIn = dqOe ? dqOut : dqDrv;

	fci_host_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
		.ceN(ceN), .weN(weN), .oeN(oeN), .byteN(byteN));
	fci_flash_model #(.MAKER(MAKER), .CONT(CONT), .DEVID(DEVID), .PSEC(6'h05)) u_flash (
		.ceN(ceN), .weN(weN), .oeN(oeN), .byteN(byteN), .flashAddr(flashAddr),
		.dq(dqIn), .dqDrv(dqDrv));

	// ----------------------------------------------------------------
	// clock, watchdog and helpers
	// ----------------------------------------------------------------
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction
	task automatic stop_test();
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		check_count++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			n_fail++;
		end
	endtask
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic ex(input logic r, input logic [18:0] a, input logic [15:0] d,
			input logic [35:0] m);
		expQ.push_back({r, a, d});
		mskQ.push_back(m);
	endtask
	task automatic unl();
		ex(0, bm ? `FCI_UNL1_BYTE : `FCI_UNL1_WORD, 16'h00AA, FULL);
		ex(0, bm ? `FCI_UNL2_BYTE : `FCI_UNL2_WORD, 16'h0055, FULL);
	endtask
	task automatic cmd(input logic [7:0] c);
		ex(0, bm ? `FCI_UNL1_BYTE : `FCI_UNL1_WORD, {8'h00, c}, FULL);
	endtask
	// order an op, wait for idle, then compare flags and the pin traffic
	task automatic run(input logic [3:0] op, input logic [18:0] a, input logic [15:0] d,
			input logic rf);
		apb(1, `FCI_REG_ADDR, {13'h0, a});
		apb(1, `FCI_REG_WDATA, {16'h0, d});
		apb(1, `FCI_REG_CTRL, {28'h0, op});
		if (op == `FCI_OP_PROGRAM)
			apb(1, `FCI_REG_CTRL, {28'h0, `FCI_OP_RESET});
		do apb(0, `FCI_REG_STATUS, 32'h0); while (rd[`FCI_ST_BUSY] !== 1'b0);
		chk({31'h0, rd[5:1]}, {31'h0, ~rf, rf, sus, idm, byp});
		chk(36'(u_flash.evLog.size()), 36'(expQ.size()));
		for (int i = 0; i < expQ.size(); i++)
			chk(u_flash.evLog[i] & mskQ[i], expQ[i] & mskQ[i]);
		u_flash.evLog.delete();
		expQ.delete();
		mskQ.delete();
		apb(1, `FCI_REG_STATUS, 32'h30);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [18:0] a;
		logic [3:0]  idOp[4] = '{4'h3, 4'h3, 4'h4, 4'h4};
		logic [18:0] idA[4]  = '{19'h00100, 19'h00101, 19'h05123, 19'h01777};
		logic [18:0] idR[4]  = '{19'h00100, 19'h00101, 19'h05002, 19'h01002};
		logic [15:0] idD[4]  = '{{8'h00, MAKER}, {8'h00, DEVID}, 16'h0001, 16'h0000};
		logic [3:0]  bypNo[5] = '{4'h1, 4'h2, 4'h6, 4'h9, 4'hA};
		repeat (8) @(posedge ref_clk);
		nrst <= 1;
		u_flash.evLog.delete();
		apb(0, `FCI_REG_STATUS, 32'h0);
		chk({4'h0, rd}, 36'h0);
		apb(0, 8'h18, 32'h0);
		chk({35'h0, err}, 36'h1);
		rnd = lfsr(rnd);
		a = {1'b0, rnd[17:0]};
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			unl();
			cmd(`FCI_CMD_PROGRAM);
			ex(0, a, rnd[15:0], FULL);
			bmem[a] = (bmem.exists(a) ? bmem[a] : 16'hFFFF) & rnd[15:0];
			run(`FCI_OP_PROGRAM, a, rnd[15:0], 0);
		end
		ex(1, a, bmem[a], FULL);
		run(`FCI_OP_READ, a, 16'h0, 0);
		apb(0, `FCI_REG_RDATA, 32'h0);
		chk({4'h0, rd}, {20'h0, bmem[a]});
		unl();
		cmd(`FCI_CMD_IDENTER);
		idm = 1;
		run(`FCI_OP_IDENTER, 19'h0, 16'h0, 0);
		run(`FCI_OP_IDENTER, 19'h0, 16'h0, 1);
		for (int k = 0; k < 4; k++) begin
			ex(1, idR[k], idD[k], FULL);
			run(idOp[k], idA[k], 16'h0, 0);
		end
		for (int k = 0; k < 4; k++)
			ex(1, 19'h00160, {8'h00, CONT}, FULL);
		ex(1, 19'h00120, {8'h00, MAKER}, FULL);
		run(`FCI_OP_CODE5, 19'h00123, 16'h0, 0);
		ex(0, 19'h0, {8'h00, `FCI_CMD_RESET}, NOADR);
		idm = 0;
		run(`FCI_OP_RESET, 19'h0, 16'h0, 0);
		run(`FCI_OP_IDREAD, 19'h0, 16'h0, 1);
		unl();
		cmd(`FCI_CMD_BYPASS);
		byp = 1;
		run(`FCI_OP_BYPENTER, 19'h0, 16'h0, 0);
		rnd = lfsr(rnd);
		ex(0, 19'h0, {8'h00, `FCI_CMD_PROGRAM}, NOADR);
		ex(0, rnd[18:0] & 19'h3FFFF, rnd[31:16], FULL);
		run(`FCI_OP_BYPPROG, rnd[18:0] & 19'h3FFFF, rnd[31:16], 0);
		for (int k = 0; k < 5; k++)
			run(bypNo[k], 19'h0, 16'h0, 1);
		ex(0, 19'h0, {8'h00, `FCI_CMD_IDENTER}, NOADR);
		ex(0, 19'h0, {8'h00, `FCI_CMD_BYPEXIT2}, NOADR);
		byp = 0;
		run(`FCI_OP_BYPEXIT, 19'h0, 16'h0, 0);
		run(`FCI_OP_BYPPROG, 19'h0, 16'h0, 1);
		apb(1, `FCI_REG_CFG, 32'h1);
		bm = 1;
		rnd = lfsr(rnd);
		unl();
		cmd(`FCI_CMD_PROGRAM);
		ex(0, rnd[18:0], rnd[15:0], 36'hFFFFF00FF);
		run(`FCI_OP_PROGRAM, rnd[18:0], rnd[15:0], 0);
		apb(1, `FCI_REG_CFG, 32'h0);
		bm = 0;
		unl();
		cmd(`FCI_CMD_ERASESU);
		unl();
		cmd(`FCI_CMD_CHIPERS);
		run(`FCI_OP_CHIPERASE, 19'h0, 16'h0, 0);
		ex(1, a, 16'hFFFF, FULL);
		run(`FCI_OP_READ, a, 16'h0, 0);
		ex(0, 19'h0, {8'h00, `FCI_CMD_SUSPEND}, NOADR);
		sus = 1;
		run(`FCI_OP_SUSPEND, 19'h0, 16'h0, 0);
		run(`FCI_OP_SUSPEND, 19'h0, 16'h0, 1);
		ex(0, 19'h0, {8'h00, `FCI_CMD_RESUME}, NOADR);
		sus = 0;
		run(`FCI_OP_RESUME, 19'h0, 16'h0, 0);
		run(`FCI_OP_RESUME, 19'h0, 16'h0, 1);
		stop_test();
	end
endmodule
`default_nettype wire
